//--- verilog/ufx_pkg.sv
// Purpose: constants shared by the usb transceiver control block
// Assumes: 8-bit special function register bus, 250 MHz clock
// Notes: all offsets, fields and reset values live here
package ufx_pkg;
	localparam logic [7:0] XCVR_CTRL_ADDR = 8'hd7;
	localparam logic [7:0] XCVR_CTRL_RESET = 8'h00;
	localparam int PULLUP_EN_BIT = 7;
	localparam int PHY_EN_BIT = 6;
	localparam int SPEED_BIT = 5;
	localparam int TEST_HI_BIT = 4;
	localparam int TEST_LO_BIT = 3;
	localparam int DIFF_BIT = 2;
	localparam int DPLUS_BIT = 1;
	localparam int DMINUS_BIT = 0;
	localparam int NUM_PIPES = 8;
	localparam logic [7:0] EP0_ADDR = 8'h00;
	localparam logic [7:0] EP_IN_BASE = 8'h80;
	localparam logic [7:0] EP_OUT_BASE = 8'h00;
	localparam logic [1:0] EP_LAST = 2'h3;
	typedef enum logic [1:0] {
		TEST_NORMAL = 2'b00,
		TEST_DIFF1 = 2'b01,
		TEST_DIFF0 = 2'b10,
		TEST_SE0 = 2'b11
	} ufx_test_t;
endpackage

//--- verilog/ufx_line_if.sv
// Purpose: carries synchronised bus line levels between modules
// Assumes: one clock domain
// Notes: producer drives levels, consumer reads them
`timescale 1ns/1ns
interface ufx_line_if;
	logic dplus_level;
	logic dminus_level;
	logic vbus_present;
	modport src (output dplus_level, output dminus_level, output vbus_present);
	modport dst (input dplus_level, input dminus_level, input vbus_present);
endinterface

//--- verilog/ufx_line_sync.sv
// Purpose: three-stage synchronisers for pin levels
// Assumes: pins are asynchronous to clk
// Notes: a change is accepted once stages two and three agree
`timescale 1ns/1ns
module ufx_line_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic dplus_pin,
	input wire logic dminus_pin,
	input wire logic vbus_pin,
	ufx_line_if.src lines
);
	logic [2:0] s1_r, s2_r, s3_r, lvl_r;
	logic [2:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

	// shift chain; stage one feeds only stage two
	always_comb begin
		s1_nxt = {vbus_pin, dplus_pin, dminus_pin};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		lvl_nxt = lvl_r;
		for (int i = 0; i < 3; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			lvl_r <= 3'h0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign lines.dminus_level = lvl_r[0];
	assign lines.dplus_level = lvl_r[1];
	assign lines.vbus_present = lvl_r[2];
endmodule

//--- verilog/ufx_function.sv
// Purpose: usb function front end: transceiver control register, pull-up steering, endpoint address match
// Assumes: cpu reaches the control register by an 8-bit sfr port with write and read strobes
// Notes: packet engine and fifo sit elsewhere; this block hands them a pipe match
// Notes: the clock order flag is sticky; only reset clears it
`timescale 1ns/1ns

module ufx_function (
	clk,
	rst,
	sfr_addr,
	sfr_wdata,
	sfr_wr,
	sfr_rd,
	sfr_rdata,
	sfr_hit,
	dplus_pin,
	dminus_pin,
	vbus_pin,
	usb_clk_running,
	pullup_dplus_en,
	pullup_dminus_en,
	phy_enabled,
	phy_suspend,
	full_speed,
	tx_force_en,
	tx_force_dplus,
	tx_force_dminus,
	token_addr,
	token_in,
	pipe_hit,
	pipe_index,
	clock_order_fault
);
	input wire logic clk;
	input wire logic rst;
	input wire logic [7:0] sfr_addr;
	input wire logic [7:0] sfr_wdata;
	input wire logic sfr_wr;
	input wire logic sfr_rd;
	output logic [7:0] sfr_rdata;
	output logic sfr_hit;
	input wire logic dplus_pin;
	input wire logic dminus_pin;
	input wire logic vbus_pin;
	input wire logic usb_clk_running;
	output logic pullup_dplus_en;
	output logic pullup_dminus_en;
	output logic phy_enabled;
	output logic phy_suspend;
	output logic full_speed;
	output logic tx_force_en;
	output logic tx_force_dplus;
	output logic tx_force_dminus;
	input wire logic [3:0] token_addr;
	input wire logic token_in;
	output logic pipe_hit;
	output logic [2:0] pipe_index;
	output logic clock_order_fault;

	ufx_line_if lines ();

	ufx_line_sync u_sync (
		.clk(clk),
		.rst(rst),
		.dplus_pin(dplus_pin),
		.dminus_pin(dminus_pin),
		.vbus_pin(vbus_pin),
		.lines(lines)
	);

	// writable part of the control register
	logic pullup_enable_r, pullup_enable_nxt;
	logic phy_enable_r, phy_enable_nxt;
	logic speed_r, speed_nxt;
	ufx_pkg::ufx_test_t phy_test_select_r, phy_test_select_nxt;
	// line status and read path
	logic differential_receive_state;
	logic [7:0] ctrl_view;
	logic [7:0] rdata_r, rdata_nxt;
	// pin drive registers
	logic pu_dp_r, pu_dp_nxt, pu_dm_r, pu_dm_nxt;
	logic frc_en_r, frc_en_nxt, frc_dp_r, frc_dp_nxt, frc_dm_r, frc_dm_nxt;
	// clock order watch
	logic fault_r, fault_nxt;
	logic clk_sync1_r, clk_sync2_r, clk_sync3_r, clk_ok_r;
	logic clk_sync1_nxt, clk_sync2_nxt, clk_sync3_nxt, clk_ok_nxt;
	// pipe match
	logic hit_r, hit_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic sel;

	// usb protocol address that a token names; endpoint zero answers 0x00 in both directions
	function automatic logic [7:0] ufx_proto_addr(input logic [3:0] ep, input logic dir_in);
		logic [7:0] res;
		res = ufx_pkg::EP0_ADDR;
		if (ep != 4'h0 && dir_in) begin
			res = ufx_pkg::EP_IN_BASE | {4'h0, ep};
		end else if (ep != 4'h0) begin
			res = ufx_pkg::EP_OUT_BASE | {4'h0, ep};
		end
		return res;
	endfunction

	// protocol address served by a pipe: pipe 2n+1 is the IN half of endpoint n, pipe 2n its OUT half
	function automatic logic [7:0] ufx_pipe_addr(input logic [2:0] pipe);
		logic [7:0] res;
		res = ufx_pkg::EP0_ADDR; // pipes 0 and 1 both belong to endpoint zero
		if (pipe[2:1] != 2'h0 && pipe[0]) begin
			res = ufx_pkg::EP_IN_BASE | {6'h0, pipe[2:1]};
		end else if (pipe[2:1] != 2'h0) begin
			res = ufx_pkg::EP_OUT_BASE | {6'h0, pipe[2:1]};
		end
		return res;
	endfunction

	assign sel = (sfr_addr == ufx_pkg::XCVR_CTRL_ADDR);

	// usb clock running flag: asynchronous, so three stages with agreement
	always_comb begin
		clk_sync1_nxt = usb_clk_running;
		clk_sync2_nxt = clk_sync1_r;
		clk_sync3_nxt = clk_sync2_r;
		clk_ok_nxt = clk_ok_r;
		if (clk_sync2_r == clk_sync3_r) begin
			clk_ok_nxt = clk_sync3_r;
		end
	end

	// register the clock flag chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_sync1_r <= 1'b0;
			clk_sync2_r <= 1'b0;
			clk_sync3_r <= 1'b0;
			clk_ok_r <= 1'b0;
		end else begin
			clk_sync1_r <= clk_sync1_nxt;
			clk_sync2_r <= clk_sync2_nxt;
			clk_sync3_r <= clk_sync3_nxt;
			clk_ok_r <= clk_ok_nxt;
		end
	end

	// differential receiver only meaningful while phy is on
	assign differential_receive_state = phy_enable_r & lines.dplus_level & ~lines.dminus_level;

	// read view of the control register
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[ufx_pkg::PULLUP_EN_BIT] = pullup_enable_r;
		ctrl_view[ufx_pkg::PHY_EN_BIT] = phy_enable_r;
		ctrl_view[ufx_pkg::SPEED_BIT] = speed_r;
		ctrl_view[ufx_pkg::TEST_HI_BIT:ufx_pkg::TEST_LO_BIT] = phy_test_select_r;
		ctrl_view[ufx_pkg::DIFF_BIT] = differential_receive_state;
		ctrl_view[ufx_pkg::DPLUS_BIT] = lines.dplus_level;
		ctrl_view[ufx_pkg::DMINUS_BIT] = lines.dminus_level;
	end

	// register writes; status bits 2..0 ignore writes
	always_comb begin
		pullup_enable_nxt = pullup_enable_r;
		phy_enable_nxt = phy_enable_r;
		speed_nxt = speed_r;
		phy_test_select_nxt = phy_test_select_r;
		rdata_nxt = rdata_r;
		fault_nxt = fault_r;
		if (sfr_wr && sel) begin
			pullup_enable_nxt = sfr_wdata[ufx_pkg::PULLUP_EN_BIT];
			phy_enable_nxt = sfr_wdata[ufx_pkg::PHY_EN_BIT];
			speed_nxt = sfr_wdata[ufx_pkg::SPEED_BIT];
			phy_test_select_nxt = ufx_pkg::ufx_test_t'(sfr_wdata[ufx_pkg::TEST_HI_BIT:ufx_pkg::TEST_LO_BIT]);
			// note a phy turn-on made before the usb clock runs
			if (sfr_wdata[ufx_pkg::PHY_EN_BIT] && !phy_enable_r && !clk_ok_r) begin
				fault_nxt = 1'b1;
			end
		end
		// read data is captured once per strobe and stands until the next
		if (sfr_rd && sel) begin
			rdata_nxt = ctrl_view;
		end else if (sfr_rd) begin
			rdata_nxt = 8'h00;
		end
	end

	// register the control fields and read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup_enable_r <= ufx_pkg::XCVR_CTRL_RESET[ufx_pkg::PULLUP_EN_BIT];
			phy_enable_r <= ufx_pkg::XCVR_CTRL_RESET[ufx_pkg::PHY_EN_BIT];
			speed_r <= ufx_pkg::XCVR_CTRL_RESET[ufx_pkg::SPEED_BIT];
			phy_test_select_r <= ufx_pkg::TEST_NORMAL;
			rdata_r <= 8'h00;
			fault_r <= 1'b0;
		end else begin
			pullup_enable_r <= pullup_enable_nxt;
			phy_enable_r <= phy_enable_nxt;
			speed_r <= speed_nxt;
			phy_test_select_r <= phy_test_select_nxt;
			rdata_r <= rdata_nxt;
			fault_r <= fault_nxt;
		end
	end

	// pull-up steering and test drive
	always_comb begin
		pu_dp_nxt = pullup_enable_r & lines.vbus_present & speed_r;
		pu_dm_nxt = pullup_enable_r & lines.vbus_present & ~speed_r;
		frc_en_nxt = 1'b0;
		frc_dp_nxt = 1'b0;
		frc_dm_nxt = 1'b0;
		if (phy_enable_r) begin
			unique case (phy_test_select_r)
				ufx_pkg::TEST_NORMAL: begin
					frc_en_nxt = 1'b0;
				end
				ufx_pkg::TEST_DIFF1: begin
					frc_en_nxt = 1'b1;
					frc_dp_nxt = 1'b1;
				end
				ufx_pkg::TEST_DIFF0: begin
					frc_en_nxt = 1'b1;
					frc_dm_nxt = 1'b1;
				end
				ufx_pkg::TEST_SE0: begin
					frc_en_nxt = 1'b1;
				end
			endcase
		end
	end

	// register the pin controls so the pins never see a combinational glitch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pu_dp_r <= 1'b0;
			pu_dm_r <= 1'b0;
			frc_en_r <= 1'b0;
			frc_dp_r <= 1'b0;
			frc_dm_r <= 1'b0;
		end else begin
			pu_dp_r <= pu_dp_nxt;
			pu_dm_r <= pu_dm_nxt;
			frc_en_r <= frc_en_nxt;
			frc_dp_r <= frc_dp_nxt;
			frc_dm_r <= frc_dm_nxt;
		end
	end

	// endpoint pipe match, only a function answers tokens; the lowest matching pipe wins, so endpoint zero is pipe 0
	always_comb begin
		logic [7:0] proto;
		proto = ufx_proto_addr(token_addr, token_in);
		hit_nxt = 1'b0;
		idx_nxt = idx_r;
		if (phy_enable_r && token_addr <= {2'h0, ufx_pkg::EP_LAST}) begin
			for (int p = ufx_pkg::NUM_PIPES - 1; p >= 0; p--) begin
				if (ufx_pipe_addr(3'(p)) == proto) begin
					hit_nxt = 1'b1;
					idx_nxt = 3'(p);
				end
			end
		end
	end

	// register the pipe match
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hit_r <= 1'b0;
			idx_r <= 3'h0;
		end else begin
			hit_r <= hit_nxt;
			idx_r <= idx_nxt;
		end
	end

	// no host outputs exist: this block only ever answers
	assign pullup_dplus_en = pu_dp_r;
	assign pullup_dminus_en = pu_dm_r;
	assign phy_enabled = phy_enable_r;
	assign phy_suspend = ~phy_enable_r;
	assign full_speed = speed_r;
	assign tx_force_en = frc_en_r;
	assign tx_force_dplus = frc_dp_r;
	assign tx_force_dminus = frc_dm_r;
	assign sfr_rdata = rdata_r;
	assign sfr_hit = sel & (sfr_rd | sfr_wr);
	assign pipe_hit = hit_r;
	assign pipe_index = idx_r;
	assign clock_order_fault = fault_r;
endmodule

//--- test/ufx_function_asserts.sv
// Purpose: concurrent checks on the usb function top ports
// Assumes: one clock, rst async active high
// Notes: bound to every ufx_function instance
`timescale 1ns/1ns
module ufx_function_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic vbus_pin,
	input wire logic pullup_dplus_en,
	input wire logic pullup_dminus_en,
	input wire logic phy_enabled,
	input wire logic phy_suspend,
	input wire logic full_speed,
	input wire logic tx_force_en,
	input wire logic [3:0] token_addr,
	input wire logic token_in,
	input wire logic pipe_hit,
	input wire logic [2:0] pipe_index
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// control register strobes
	sequence s_ctrl_wr;
		sfr_wr && sfr_addr == 8'hd7;
	endsequence
	sequence s_ctrl_rd;
		sfr_rd && sfr_addr == 8'hd7;
	endsequence
	// register fields, read path and reset
	reg_write_a: assert property (s_ctrl_wr |=> phy_enabled == $past(sfr_wdata[6]))
		else $error("phy enable write lost");
	suspend_mode_a: assert property (phy_suspend != phy_enabled)
		else $error("suspend not inverse of enable");
	rd_answer_a: assert property (s_ctrl_rd |=> sfr_rdata[6:5] == $past({phy_enabled, full_speed}))
		else $error("read data fields wrong");
	diff_bit_a: assert property (s_ctrl_rd |=> sfr_rdata[2] == ($past(phy_enabled) && sfr_rdata[1] && !sfr_rdata[0]))
		else $error("differential bit wrong");
	unmapped_rd_a: assert property (sfr_rd && sfr_addr != 8'hd7 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	hit_flag_a: assert property (sfr_hit == ((sfr_rd || sfr_wr) && sfr_addr == 8'hd7))
		else $error("register hit flag wrong");
	reset_clear_a: assert property ($fell(rst) |-> !phy_enabled && !full_speed && !pullup_dplus_en)
		else $error("outputs not cleared by reset");
	// pull-up steering and gating
	pu_dplus_a: assert property (pullup_dplus_en |-> $past(full_speed) && !pullup_dminus_en)
		else $error("dplus pull-up at low speed");
	pu_dminus_a: assert property (pullup_dminus_en |-> !$past(full_speed))
		else $error("dminus pull-up at full speed");
	vbus_gate_a: assert property ((!vbus_pin)[*7] |-> !pullup_dplus_en && !pullup_dminus_en)
		else $error("pull-up without vbus");
	// pipe match and test drive
	ep_zero_a: assert property (phy_enabled && token_addr == 4'h0 |=> pipe_hit && pipe_index == 3'h0)
		else $error("endpoint zero miss");
	ep_pair_a: assert property (phy_enabled && token_addr inside {[1:3]} |=>
		pipe_hit && pipe_index == $past({token_addr[1:0], token_in}))
		else $error("endpoint pair miss");
	force_gate_a: assert property (tx_force_en |-> $past(phy_enabled))
		else $error("test drive while phy off");
endmodule
bind ufx_function ufx_function_asserts i_chk (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .vbus_pin(vbus_pin),
	.pullup_dplus_en(pullup_dplus_en),
	.pullup_dminus_en(pullup_dminus_en), .phy_enabled(phy_enabled), .phy_suspend(phy_suspend),
	.full_speed(full_speed), .tx_force_en(tx_force_en), .token_addr(token_addr), .token_in(token_in),
	.pipe_hit(pipe_hit), .pipe_index(pipe_index));

//--- test/ufx_host_model.sv
// Purpose: usb host side of the cable: line drive and vbus
// Assumes: host pull-downs on both lines
// Notes: released lines follow the function's pull-up
`timescale 1ns/1ns
module ufx_host_model (
	input wire logic [1:0] drive,
	input wire logic vbus_on,
	input wire logic pullup_dplus_en,
	input wire logic pullup_dminus_en,
	output logic dplus_pin,
	output logic dminus_pin,
	output logic vbus_pin
);
	// 1 differential one, 2 differential zero, 3 single-ended zero, 0 released
	always_comb begin
		case (drive)
			2'h1: {dplus_pin, dminus_pin} = 2'b10;
			2'h2: {dplus_pin, dminus_pin} = 2'b01;
			2'h3: {dplus_pin, dminus_pin} = 2'b00;
			default: {dplus_pin, dminus_pin} = {pullup_dplus_en, pullup_dminus_en};
		endcase
	end
	assign vbus_pin = vbus_on;
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench for the usb function front end
// Assumes: 250 MHz clock, line sync settles within 8 cycles
// Notes: pipe matches from a row table, the rest by hand
`timescale 1ns/1ns
module testbench;
	logic clk, rst, sfr_wr, sfr_rd, sfr_hit, vbus_pin, dplus_pin, dminus_pin, usb_clk_running, vbus_on;
	logic pullup_dplus_en, pullup_dminus_en, phy_enabled, phy_suspend, full_speed, token_in, pipe_hit, clock_order_fault;
	logic tx_force_en, tx_force_dplus, tx_force_dminus;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
	logic [3:0] token_addr;
	logic [2:0] pipe_index;
	logic [1:0] drive;
	logic [8:0] rows [10] = '{9'h008, 9'h018, 9'h02a, 9'h03b, 9'h04c, 9'h05d, 9'h06e, 9'h07f, 9'h090, 9'h1e0};
	int error_cnt = 0;
	int check_count = 0;
	ufx_function i_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .dplus_pin(dplus_pin), .dminus_pin(dminus_pin),
		.vbus_pin(vbus_pin), .usb_clk_running(usb_clk_running), .pullup_dplus_en(pullup_dplus_en),
		.pullup_dminus_en(pullup_dminus_en), .phy_enabled(phy_enabled), .phy_suspend(phy_suspend),
		.full_speed(full_speed), .tx_force_en(tx_force_en), .tx_force_dplus(tx_force_dplus),
		.tx_force_dminus(tx_force_dminus), .token_addr(token_addr), .token_in(token_in), .pipe_hit(pipe_hit),
		.pipe_index(pipe_index), .clock_order_fault(clock_order_fault));
	ufx_host_model i_host (.drive(drive), .vbus_on(vbus_on), .pullup_dplus_en(pullup_dplus_en),
		.pullup_dminus_en(pullup_dminus_en), .dplus_pin(dplus_pin), .dminus_pin(dminus_pin), .vbus_pin(vbus_pin));
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// compare and count
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// register write then read with strobes launched after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		#1 v = sfr_rdata;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		{sfr_addr, sfr_wdata, sfr_wr, sfr_rd, token_addr, token_in, usb_clk_running, drive, vbus_on} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(8'hd7, d);
		chk("reset value", d, 8'h00);
		chk("suspend", {7'h0, phy_suspend}, 8'h01);
		usb_clk_running <= 1'b1; // clock runs before the transceiver is enabled
		rd(8'h55, d);
		chk("unmapped read", d, 8'h00);
		vbus_on <= 1'b1;
		wr(8'he0, 8'hff);
		wr(8'hd7, 8'he0);
		repeat (8) @(posedge clk);
		chk("full speed pullups", {6'h0, pullup_dminus_en, pullup_dplus_en}, 8'h01);
		rd(8'hd7, d);
		chk("full speed status", d, 8'he6);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			{token_addr, token_in} <= rows[i][8:4];
			repeat (2) @(posedge clk);
			chk("pipe hit", {7'h0, pipe_hit}, {7'h0, rows[i][3]});
			if (rows[i][3]) chk("pipe index", {5'h0, pipe_index}, {5'h0, rows[i][2:0]});
		end
		wr(8'hd7, 8'hc0);
		repeat (8) @(posedge clk);
		chk("low speed pullups", {6'h0, pullup_dminus_en, pullup_dplus_en}, 8'h02);
		rd(8'hd7, d);
		chk("low speed status", d, 8'hc1);
		vbus_on <= 1'b0;
		repeat (8) @(posedge clk);
		chk("no vbus pullups", {6'h0, pullup_dminus_en, pullup_dplus_en}, 8'h00);
		vbus_on <= 1'b1;
		wr(8'hd7, 8'h40);
		repeat (8) @(posedge clk);
		chk("detached pullups", {6'h0, pullup_dminus_en, pullup_dplus_en}, 8'h00);
		chk("normal drive", {7'h0, tx_force_en}, 8'h00);
		for (int t = 1; t < 4; t++) begin
			wr(8'hd7, 8'(8'h40 | (t << 3)));
			repeat (2) @(posedge clk);
			chk("test drive", {5'h0, tx_force_en, tx_force_dplus, tx_force_dminus}, {5'h0, 1'b1, t == 1, t == 2});
		end
		wr(8'hd7, 8'h08);
		drive <= 2'h2;
		repeat (8) @(posedge clk);
		chk("phy off", {6'h0, tx_force_en, phy_suspend}, 8'h01);
		rd(8'hd7, d);
		chk("suspended status", d, 8'h09);
		drive <= 2'h1;
		wr(8'hd7, 8'h1f);
		repeat (8) @(posedge clk);
		rd(8'hd7, d);
		chk("read-only bits", d, 8'h1a);
		chk("clock order", {7'h0, clock_order_fault}, 8'h00);
		// second reset in mid-run, then a transceiver turn-on before the usb clock is seen
		usb_clk_running <= 1'b0;
		drive <= 2'h0;
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(8'hd7, d);
		chk("second reset value", d, 8'h00);
		wr(8'hd7, 8'h40);
		@(posedge clk);
		chk("clock order fault", {7'h0, clock_order_fault}, 8'h01);
		chk("phy on after reset", {7'h0, phy_enabled}, 8'h01);
		final_report();
	end
endmodule
